//--- rtl/rtcal_top.sv
// Functional notes
// - Writes to clock registers need the unlock signature in both key halves.
// - CPU writes to clock registers are applied on crystal clock edges.
// - Written value appears after two further crystal clock periods.
// - Clock register writes only act while the oscillator is enabled.
// - Writing one to the isolation control releases isolation.
// - Without oscillator, release and key, unit stays isolated; clock register writes ignored.
// - Own power-on reset loads the reset values into all clock domain registers; date and month reset to 01.
// - Device reset does not disturb clock domain flops.
// - Hundred-year calendar stops at year 2099.
// - Counts ms to year in 24-hour form with leap February.
// - Time, calendar and alarm are BCD, one digit per nibble.
// - Alarm matches at second, minute, hour or day granularity.
// - Periodic event each ms, second, minute, hour or day.
// - All alarm and periodic sources merge into one interrupt line.
// - Alarm, periodic or wake input raise the wake request.
// - Wake pin may act as an input from an outside device.
// - Wake pin may be driven out to wake an outside device.
// - Scratch registers survive device resets.
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/1ps
module rtcal_top
   import rtcal_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   // Clocks and resets
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              rtc_por_n,
   // APB slave
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [31:0]       pwdata,
   output logic                   pready,
   output logic [31:0]            prdata,
   output logic                   pslverr,
   // Crystal clock, sampled
   input  wire logic              xtal_clk_i,
   // Wake pin
   input  wire logic              wake_pin_i,
   output logic                   wake_pin_o,
   output logic                   wake_pin_oe_n,
   // Events to the CPU
   output logic                   irq,
   output logic                   wake_req
);
   import rtcal_pkg::*;

   if (ADDR_W < 8) begin : g_chk
      $error("rtcal_top needs at least eight address bits");
   end

   logic [1:0]  pins_s;
   logic        xtal_q_ff;
   logic        wake_q_ff;
   logic        tick;
   logic [16:0] acc_ff;
   logic [16:0] acc_sum;
   logic        ms_inc, sec_inc, min_inc, hour_inc, day_inc, mon_inc, year_inc;
   logic        ms_hi, sec_hi, min_hi, hour_hi, date_hi, mon_hi, wday_hi;
   logic        at_end;
   logic [11:0] ms_q;
   logic [7:0]  sec_q, min_q, hour_q, date_q, mon_q, year_q;
   logic [3:0]  wday_q;
   logic [7:0]  mdays;
   logic        leap;
   logic        osc_en_ff, iso_rel_ff;
   logic [15:0] key_lo_ff, key_hi_ff;
   logic        isolated;
   logic        pend_ff;
   logic [7:0]  pend_addr_ff;
   logic [31:0] pend_data_ff;
   logic [1:0]  pend_cnt_ff;
   logic        apply;
   logic [7:0]  asec_ff, amin_ff, ahour_ff, adate_ff, ctrl_ff, corr_ff;
   logic [31:0] scr0_ff, scr1_ff;
   logic        alm_flag_ff, per_flag_ff, wk_flag_ff;
   logic [2:0]  flags_s;
   logic        match, match_q_ff, alm_set, per_set, wk_set;
   logic [7:0]  off;
   logic        addr_ok, gated, wr_fire;
   logic [31:0] rd_data;
   rtcal_alm_e  alm_mode;
   rtcal_per_e  per_sel;

   // Pin inputs cross into the logic through two flops
   rtcal_sync #(.W(2)) u_pin_sync (
      .clk   (pclk),
      .rst_n (rtc_por_n),
      .d     ({wake_pin_i, xtal_clk_i}),
      .q     (pins_s)
   );

   assign tick = pins_s[0] & ~xtal_q_ff;

   // power-on reset only; device reset not used here
   always_ff @(posedge pclk or negedge rtc_por_n) begin
      if (!rtc_por_n) begin
         xtal_q_ff <= 1'b0;
         wake_q_ff <= 1'b0;
      end else begin
         xtal_q_ff <= pins_s[0];
         wake_q_ff <= pins_s[1];
      end
   end

   // fractional divider with signed correction per crystal edge
   assign acc_sum = acc_ff + ACC_STEP + {{9{corr_ff[7]}}, corr_ff};
   // the chain freezes at the last instant of 2099
   assign at_end  = (year_q == 8'h99) & mon_hi & date_hi & hour_hi & min_hi & sec_hi & ms_hi;
   assign ms_inc  = tick & (acc_sum >= ACC_WRAP) & ~at_end;

   always_ff @(posedge pclk or negedge rtc_por_n) begin
      if (!rtc_por_n) begin
         acc_ff <= '0;
      end else if (tick) begin
         acc_ff <= (acc_sum >= ACC_WRAP) ? acc_sum - ACC_WRAP : acc_sum;
      end
   end

   // carry chain from milliseconds to year
   assign sec_inc  = ms_inc & ms_hi;
   assign min_inc  = sec_inc & sec_hi;
   assign hour_inc = min_inc & min_hi;
   assign day_inc  = hour_inc & hour_hi;
   assign mon_inc  = day_inc & date_hi;
   assign year_inc = mon_inc & mon_hi;

   // years 00 to 99 all lie in 2000 to 2099, so 00 is leap
   always_comb begin
      leap = (~year_q[4] & (year_q[3:0] == 4'h0 || year_q[3:0] == 4'h4 || year_q[3:0] == 4'h8))
           | (year_q[4] & (year_q[3:0] == 4'h2 || year_q[3:0] == 4'h6));
      case (mon_q)
         8'h02:   mdays = leap ? 8'h29 : 8'h28;
         8'h04,
         8'h06,
         8'h09,
         8'h11:   mdays = 8'h30;
         default: mdays = 8'h31;
      endcase
   end

   // writes land on the second crystal edge after capture
   assign apply = pend_ff & tick & (pend_cnt_ff == APPLY_TICKS - 2'h1);

   // every field is a chain of BCD digits
   rtcal_bcd_cnt #(.W(12), .RST(RST_MSEC)) u_ms (
      .clk(pclk), .rst_n(rtc_por_n), .inc(ms_inc),
      .ld(apply && pend_addr_ff == OFF_MSEC), .ld_val(pend_data_ff[11:0]),
      .lo(12'h000), .hi(12'h999), .q(ms_q), .at_hi(ms_hi)
   );
   rtcal_bcd_cnt #(.W(8), .RST(RST_TIME)) u_sec (
      .clk(pclk), .rst_n(rtc_por_n), .inc(sec_inc),
      .ld(apply && pend_addr_ff == OFF_SEC), .ld_val(pend_data_ff[7:0]),
      .lo(8'h00), .hi(8'h59), .q(sec_q), .at_hi(sec_hi)
   );
   rtcal_bcd_cnt #(.W(8), .RST(RST_TIME)) u_min (
      .clk(pclk), .rst_n(rtc_por_n), .inc(min_inc),
      .ld(apply && pend_addr_ff == OFF_MIN), .ld_val(pend_data_ff[7:0]),
      .lo(8'h00), .hi(8'h59), .q(min_q), .at_hi(min_hi)
   );
   rtcal_bcd_cnt #(.W(8), .RST(RST_TIME)) u_hour (
      .clk(pclk), .rst_n(rtc_por_n), .inc(hour_inc),
      .ld(apply && pend_addr_ff == OFF_HOUR), .ld_val(pend_data_ff[7:0]),
      .lo(8'h00), .hi(8'h23), .q(hour_q), .at_hi(hour_hi)
   );
   rtcal_bcd_cnt #(.W(4), .RST(RST_WDAY)) u_wday (
      .clk(pclk), .rst_n(rtc_por_n), .inc(day_inc),
      .ld(apply && pend_addr_ff == OFF_WDAY), .ld_val(pend_data_ff[3:0]),
      .lo(4'h0), .hi(4'h6), .q(wday_q), .at_hi(wday_hi)
   );
   rtcal_bcd_cnt #(.W(8), .RST(RST_DATE)) u_date (
      .clk(pclk), .rst_n(rtc_por_n), .inc(day_inc),
      .ld(apply && pend_addr_ff == OFF_DATE), .ld_val(pend_data_ff[7:0]),
      .lo(8'h01), .hi(mdays), .q(date_q), .at_hi(date_hi)
   );
   rtcal_bcd_cnt #(.W(8), .RST(RST_MONTH)) u_mon (
      .clk(pclk), .rst_n(rtc_por_n), .inc(mon_inc),
      .ld(apply && pend_addr_ff == OFF_MONTH), .ld_val(pend_data_ff[7:0]),
      .lo(8'h01), .hi(8'h12), .q(mon_q), .at_hi(mon_hi)
   );
   rtcal_bcd_cnt #(.W(8), .RST(RST_YEAR)) u_year (
      .clk(pclk), .rst_n(rtc_por_n), .inc(year_inc),
      .ld(apply && pend_addr_ff == OFF_YEAR), .ld_val(pend_data_ff[7:0]),
      .lo(8'h00), .hi(8'h99), .q(year_q), .at_hi()
   );

   // APB decode; the calendar stays in the crystal timing domain
   assign off     = paddr[7:0];
   assign addr_ok = (paddr[ADDR_W-1:0] <= ADDR_W'(OFF_SCR1)) && (paddr[1:0] == 2'b00);
   assign gated   = addr_ok && (off <= OFF_ADATE || off == OFF_CTRL || off == OFF_CORR
                               || off == OFF_SCR0 || off == OFF_SCR1);
   assign wr_fire = psel & penable & pready & pwrite & ~pslverr;

   // any missing condition keeps the unit isolated
   assign isolated = ~(osc_en_ff & iso_rel_ff & ({key_hi_ff, key_lo_ff} == UNLOCK_KEY));

   // Ungated controls: oscillator, isolation release and key halves
   always_ff @(posedge pclk or negedge rtc_por_n) begin
      if (!rtc_por_n) begin
         osc_en_ff  <= 1'b0;
         iso_rel_ff <= 1'b0;
         key_lo_ff  <= '0;
         key_hi_ff  <= '0;
      end else if (wr_fire) begin
         // oscillator enable is reachable while isolated
         if (off == OFF_OSC) begin
            osc_en_ff <= pwdata[0];
         end
         // a one releases, a zero isolates again
         if (off == OFF_ISO) begin
            iso_rel_ff <= pwdata[0];
         end
         if (off == OFF_KEYLO) begin
            key_lo_ff <= pwdata[15:0];
         end
         if (off == OFF_KEYHI) begin
            key_hi_ff <= pwdata[15:0];
         end
      end
   end

   // gated writes are only captured with the key matching
   // two crystal edges counted before the value shows
   always_ff @(posedge pclk or negedge rtc_por_n) begin
      if (!rtc_por_n) begin
         pend_ff      <= 1'b0;
         pend_addr_ff <= '0;
         pend_data_ff <= '0;
         pend_cnt_ff  <= '0;
      end else if (wr_fire && gated && !isolated) begin
         pend_ff      <= 1'b1;
         pend_addr_ff <= off;
         pend_data_ff <= pwdata;
         pend_cnt_ff  <= '0;
      end else if (apply) begin
         pend_ff <= 1'b0;
      end else if (pend_ff && tick) begin
         pend_cnt_ff <= pend_cnt_ff + 2'h1;
      end
   end

   // scratch and alarm settings survive device reset
   always_ff @(posedge pclk or negedge rtc_por_n) begin
      if (!rtc_por_n) begin
         asec_ff  <= RST_TIME;
         amin_ff  <= RST_TIME;
         ahour_ff <= RST_TIME;
         adate_ff <= RST_DATE;
         ctrl_ff  <= RST_CTRL;
         corr_ff  <= '0;
         scr0_ff  <= '0;
         scr1_ff  <= '0;
      end else if (apply) begin
         case (pend_addr_ff)
            OFF_ASEC:  asec_ff  <= pend_data_ff[7:0];
            OFF_AMIN:  amin_ff  <= pend_data_ff[7:0];
            OFF_AHOUR: ahour_ff <= pend_data_ff[7:0];
            OFF_ADATE: adate_ff <= pend_data_ff[7:0];
            OFF_CTRL:  ctrl_ff  <= pend_data_ff[7:0];
            OFF_CORR:  corr_ff  <= pend_data_ff[7:0];
            OFF_SCR0:  scr0_ff  <= pend_data_ff;
            OFF_SCR1:  scr1_ff  <= pend_data_ff;
            default:   ;
         endcase
      end
   end

   assign alm_mode = rtcal_alm_e'(ctrl_ff[CTRL_ALM_MODE +: 2]);
   assign per_sel  = rtcal_per_e'(ctrl_ff[CTRL_PER_SEL +: 3]);

   always_comb begin
      match = (sec_q == asec_ff);
      case (alm_mode)
         ALM_SEC:  match = match;
         ALM_MIN:  match = match & (min_q == amin_ff);
         ALM_HOUR: match = match & (min_q == amin_ff) & (hour_q == ahour_ff);
         ALM_DAY:  match = match & (min_q == amin_ff) & (hour_q == ahour_ff)
                         & (date_q == adate_ff);
         default:  match = 1'b0;
      endcase
   end
   assign alm_set = ctrl_ff[CTRL_ALM_EN] & match & ~match_q_ff;

   always_comb begin
      case (per_sel)
         PER_MS:   per_set = ms_inc;
         PER_SEC:  per_set = sec_inc;
         PER_MIN:  per_set = min_inc;
         PER_HOUR: per_set = hour_inc;
         PER_DAY:  per_set = day_inc;
         default:  per_set = 1'b0;
      endcase
      per_set = per_set & ctrl_ff[CTRL_PER_EN];
   end

   // rising edge on the pin while it is an input
   assign wk_set = ~ctrl_ff[CTRL_WAKE_DIR] & pins_s[1] & ~wake_q_ff;

   // Sticky flags; a set in the clearing cycle wins
   always_ff @(posedge pclk or negedge rtc_por_n) begin
      if (!rtc_por_n) begin
         match_q_ff  <= 1'b0;
         alm_flag_ff <= 1'b0;
         per_flag_ff <= 1'b0;
         wk_flag_ff  <= 1'b0;
      end else begin
         match_q_ff  <= match;
         alm_flag_ff <= alm_set | (alm_flag_ff & ~(wr_fire && off == OFF_STAT && pwdata[STAT_ALM]));
         per_flag_ff <= per_set | (per_flag_ff & ~(wr_fire && off == OFF_STAT && pwdata[STAT_PER]));
         wk_flag_ff  <= wk_set | (wk_flag_ff & ~(wr_fire && off == OFF_STAT && pwdata[STAT_WAKE]));
      end
   end

   // flags reach the CPU side through two flops
   rtcal_sync #(.W(3)) u_flag_sync (
      .clk   (pclk),
      .rst_n (rtc_por_n),
      .d     ({wk_flag_ff, per_flag_ff, alm_flag_ff}),
      .q     (flags_s)
   );

   // one request line; wake request; pin driven as output
   always_ff @(posedge pclk or negedge rtc_por_n) begin
      if (!rtc_por_n) begin
         irq           <= 1'b0;
         wake_req      <= 1'b0;
         wake_pin_o    <= 1'b0;
         wake_pin_oe_n <= 1'b1;
      end else begin
         irq           <= flags_s[STAT_ALM] | flags_s[STAT_PER];
         wake_req      <= |flags_s;
         wake_pin_o    <= ctrl_ff[CTRL_WAKE_DIR] & (flags_s[STAT_ALM] | flags_s[STAT_PER]);
         wake_pin_oe_n <= ~ctrl_ff[CTRL_WAKE_DIR];
      end
   end

   always_comb begin
      case (off)
         OFF_MSEC:  rd_data = 32'(ms_q);
         OFF_SEC:   rd_data = 32'(sec_q);
         OFF_MIN:   rd_data = 32'(min_q);
         OFF_HOUR:  rd_data = 32'(hour_q);
         OFF_WDAY:  rd_data = 32'(wday_q);
         OFF_DATE:  rd_data = 32'(date_q);
         OFF_MONTH: rd_data = 32'(mon_q);
         OFF_YEAR:  rd_data = 32'(year_q);
         OFF_ASEC:  rd_data = 32'(asec_ff);
         OFF_AMIN:  rd_data = 32'(amin_ff);
         OFF_AHOUR: rd_data = 32'(ahour_ff);
         OFF_ADATE: rd_data = 32'(adate_ff);
         OFF_CTRL:  rd_data = 32'(ctrl_ff);
         OFF_STAT:  rd_data = 32'({pend_ff, isolated, flags_s});
         OFF_CORR:  rd_data = 32'(corr_ff);
         OFF_OSC:   rd_data = 32'(osc_en_ff);
         OFF_ISO:   rd_data = 32'(iso_rel_ff);
         OFF_KEYLO: rd_data = 32'(key_lo_ff);
         OFF_KEYHI: rd_data = 32'(key_hi_ff);
         OFF_SCR0:  rd_data = scr0_ff;
         OFF_SCR1:  rd_data = scr1_ff;
         default:   rd_data = '0;
      endcase
      if (!addr_ok) begin
         rd_data = '0;
      end
   end

   // Bus side on device reset; a gated write waits while one is still pending
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= '0;
         pslverr <= 1'b0;
      end else if (psel && penable && !pready && !(pwrite && gated && pend_ff)) begin
         pready  <= 1'b1;
         prdata  <= pwrite ? '0 : rd_data;
         pslverr <= ~addr_ok;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // Checks
   a_key_guard: assert property (@(posedge pclk) disable iff (!rtc_por_n)
      $rose(pend_ff) |-> $past({key_hi_ff, key_lo_ff}) == UNLOCK_KEY)
      else $error("write captured without key");
   a_osc_guard: assert property (@(posedge pclk) disable iff (!rtc_por_n)
      $rose(pend_ff) |-> $past(osc_en_ff) && $past(iso_rel_ff))
      else $error("write captured with oscillator off or isolated");
   a_iso_ignore: assert property (@(posedge pclk) disable iff (!rtc_por_n)
      (isolated && !pend_ff) |=> !pend_ff)
      else $error("write taken while isolated");
   a_tick_only: assert property (@(posedge pclk) disable iff (!rtc_por_n)
      (sec_q != $past(sec_q)) |-> $past(tick))
      else $error("seconds changed off a crystal edge");
   a_apply_late: assert property (@(posedge pclk) disable iff (!rtc_por_n)
      (apply && pend_addr_ff == OFF_SEC) |=> sec_q == $past(pend_data_ff[7:0])
         && $past(pend_cnt_ff) == 2'h1)
      else $error("seconds write not applied on second edge");
   a_year_stop: assert property (@(posedge pclk) disable iff (!rtc_por_n)
      (year_q == 8'h99 && !apply) |=> year_q == 8'h99)
      else $error("year passed 2099");
   a_leap_feb: assert property (@(posedge pclk) disable iff (!rtc_por_n)
      (mon_q == 8'h02 && date_q == 8'h28 && day_inc && leap && !apply) |=> date_q == 8'h29)
      else $error("leap February lost its 29th");
   a_alarm_match: assert property (@(posedge pclk) disable iff (!rtc_por_n)
      $rose(alm_flag_ff) |-> $past(sec_q) == $past(asec_ff))
      else $error("alarm without seconds match");
   a_irq_merge: assert property (@(posedge pclk) disable iff (!rtc_por_n)
      $rose(per_flag_ff) |-> ##[2:4] irq)
      else $error("periodic flag did not raise interrupt");
   a_per_flag: assert property (@(posedge pclk) disable iff (!rtc_por_n)
      per_set |=> per_flag_ff)
      else $error("periodic event lost");
endmodule

//--- rtl/rtcal_pkg.sv
package rtcal_pkg;

   // Register byte offsets
   localparam logic [7:0] OFF_MSEC  = 8'h00;
   localparam logic [7:0] OFF_SEC   = 8'h04;
   localparam logic [7:0] OFF_MIN   = 8'h08;
   localparam logic [7:0] OFF_HOUR  = 8'h0C;
   localparam logic [7:0] OFF_WDAY  = 8'h10;
   localparam logic [7:0] OFF_DATE  = 8'h14;
   localparam logic [7:0] OFF_MONTH = 8'h18;
   localparam logic [7:0] OFF_YEAR  = 8'h1C;
   localparam logic [7:0] OFF_ASEC  = 8'h20;
   localparam logic [7:0] OFF_AMIN  = 8'h24;
   localparam logic [7:0] OFF_AHOUR = 8'h28;
   localparam logic [7:0] OFF_ADATE = 8'h2C;
   localparam logic [7:0] OFF_CTRL  = 8'h30;
   localparam logic [7:0] OFF_STAT  = 8'h34;
   localparam logic [7:0] OFF_CORR  = 8'h38;
   localparam logic [7:0] OFF_OSC   = 8'h3C;
   localparam logic [7:0] OFF_ISO   = 8'h40;
   localparam logic [7:0] OFF_KEYLO = 8'h44;
   localparam logic [7:0] OFF_KEYHI = 8'h48;
   localparam logic [7:0] OFF_SCR0  = 8'h4C;
   localparam logic [7:0] OFF_SCR1  = 8'h50;

   // Unlock signature, high half then low half
   localparam logic [31:0] UNLOCK_KEY = 32'h95A4_F1E0;

   // Control register fields
   localparam int CTRL_ALM_EN    = 0;
   localparam int CTRL_ALM_MODE  = 1;
   localparam int CTRL_PER_EN    = 3;
   localparam int CTRL_PER_SEL   = 4;
   localparam int CTRL_WAKE_DIR  = 7;

   // Status register fields
   localparam int STAT_ALM   = 0;
   localparam int STAT_PER   = 1;
   localparam int STAT_WAKE  = 2;
   localparam int STAT_ISO   = 3;
   localparam int STAT_BUSY  = 4;

   // Reset values of the calendar
   localparam logic [11:0] RST_MSEC  = 12'h000;
   localparam logic [7:0]  RST_TIME  = 8'h00;
   localparam logic [3:0]  RST_WDAY  = 4'h0;
   localparam logic [7:0]  RST_DATE  = 8'h01;
   localparam logic [7:0]  RST_MONTH = 8'h01;
   localparam logic [7:0]  RST_YEAR  = 8'h00;
   localparam logic [7:0]  RST_CTRL  = 8'h00;

   // Crystal and millisecond divider
   localparam int XTAL_HZ = 32768;
   localparam int MS_HZ   = 1000;
   localparam logic [16:0] ACC_STEP = 17'(MS_HZ);
   localparam logic [16:0] ACC_WRAP = 17'(XTAL_HZ);

   // Crystal edges from write to visibility; least CPU to crystal ratio
   localparam logic [1:0] APPLY_TICKS = 2'h2;
   localparam int CPU_XTAL_RATIO = 3;

   typedef enum logic [1:0] {ALM_SEC, ALM_MIN, ALM_HOUR, ALM_DAY} rtcal_alm_e;
   typedef enum logic [2:0] {PER_MS, PER_SEC, PER_MIN, PER_HOUR, PER_DAY} rtcal_per_e;

endpackage

//--- rtl/rtcal_sync.sv
`timescale 1ns/1ps
module rtcal_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_ff;

   if (W < 1) begin : g_chk
      $error("rtcal_sync width must be at least one");
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff <= '0;
         q       <= '0;
      end else begin
         meta_ff <= d;
         q       <= meta_ff;
      end
   end
endmodule

//--- rtl/rtcal_bcd_cnt.sv
`timescale 1ns/1ps
module rtcal_bcd_cnt #(
   parameter int           W   = 8,
   parameter logic [W-1:0] RST = '0
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Control
   input  wire logic         inc,
   input  wire logic         ld,
   input  wire logic [W-1:0] ld_val,
   input  wire logic [W-1:0] lo,
   input  wire logic [W-1:0] hi,
   // Count
   output logic      [W-1:0] q,
   output logic              at_hi
);
   if (W % 4 != 0 || W < 4) begin : g_chk
      $error("rtcal_bcd_cnt width must be whole nibbles");
   end

   function automatic logic [W-1:0] bcd_inc(input logic [W-1:0] v);
      logic [W-1:0] r;
      logic         c;
      r = v;
      c = 1'b1;
      for (int i = 0; i < W / 4; i++) begin
         if (c) begin
            if (v[i*4 +: 4] >= 4'h9) begin
               r[i*4 +: 4] = 4'h0;
            end else begin
               r[i*4 +: 4] = v[i*4 +: 4] + 4'h1;
               c = 1'b0;
            end
         end
      end
      return r;
   endfunction

   // Loaded values above the limit wrap at the next step
   assign at_hi = (q >= hi);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= RST;
      end else if (ld) begin
         q <= ld_val;
      end else if (inc) begin
         q <= at_hi ? lo : bcd_inc(q);
      end
   end
endmodule

//--- bench/tb_rtcal_top.sv
`timescale 1ns/1ps
module tb_rtcal_top;
   import rtcal_pkg::*;
   typedef struct packed {
      logic [7:0]  a;
      logic        w;
      logic [31:0] d;
      logic [31:0] e;
      logic        err;
   } rtcal_row_s;
   logic        pclk      = 1'h0;
   logic        presetn   = 1'h0;
   logic        rtc_por_n = 1'h0;
   logic [7:0]  paddr     = 8'h00;
   logic        psel      = 1'h0;
   logic        penable   = 1'h0;
   logic        pwrite    = 1'h0;
   logic [31:0] pwdata    = 32'h0;
   logic        xtal      = 1'h0;
   logic        wake_in   = 1'h0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic        pready, pslverr, wake_o, wake_oe_n, irq, wake_req, er;
   int          failures        = 0;
   int          samples_checked = 0;
   rtcal_row_s  rows [16];
   rtcal_top #(.ADDR_W(8)) uut (
      .pclk(pclk), .presetn(presetn), .rtc_por_n(rtc_por_n), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .xtal_clk_i(xtal), .wake_pin_i(wake_in), .wake_pin_o(wake_o),
      .wake_pin_oe_n(wake_oe_n), .irq(irq), .wake_req(wake_req));
   always #25 pclk = ~pclk;
   always begin
      repeat (4) @(posedge pclk);
      xtal <= ~xtal;
   end
   task end_sim;
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Busy gated writes stall pready, so the wait is open-ended but bounded
   task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'h1; penable <= 1'h0; paddr <= a; pwrite <= w; pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do begin @(posedge pclk); n++; end while (pready !== 1'h1 && n < 5000);
      if (n >= 5000) failures++;
      rd = prdata;
      er = pslverr;
      psel <= 1'h0; penable <= 1'h0;
   endtask
   task rc(input logic [7:0] a, input logic [31:0] e);
      apb(a, 1'h0, 32'h0);
      chk(rd, e);
   endtask
   task setcal(input logic [31:0] y, input logic [31:0] mo, input logic [31:0] d);
      apb(OFF_YEAR, 1'h1, y); apb(OFF_MONTH, 1'h1, mo); apb(OFF_DATE, 1'h1, d);
      apb(OFF_HOUR, 1'h1, 32'h23); apb(OFF_MIN, 1'h1, 32'h59);
      apb(OFF_SEC, 1'h1, 32'h59); apb(OFF_MSEC, 1'h1, 32'h999);
   endtask
   task wait_irq;
      int n;
      n = 0;
      while (irq !== 1'h1 && n < 1000) begin @(posedge pclk); n++; end
   endtask
   initial begin
      repeat (40000) @(posedge pclk);
      failures++;
      end_sim();
   end
   initial begin
      rows = '{'{OFF_MSEC, 1'h0, 32'h0, 32'h000, 1'h0}, '{OFF_DATE, 1'h0, 32'h0, 32'h01, 1'h0},
         '{OFF_MONTH, 1'h0, 32'h0, 32'h01, 1'h0}, '{OFF_YEAR, 1'h0, 32'h0, 32'h00, 1'h0},
         '{OFF_STAT, 1'h0, 32'h0, 32'h08, 1'h0}, '{OFF_SCR0, 1'h1, 32'h11, 32'h0, 1'h0},
         '{OFF_OSC, 1'h1, 32'h1, 32'h0, 1'h0}, '{OFF_ISO, 1'h1, 32'h1, 32'h0, 1'h0},
         '{OFF_KEYLO, 1'h1, 32'hF1E0, 32'h0, 1'h0}, '{OFF_KEYHI, 1'h1, 32'h1234, 32'h0, 1'h0},
         '{OFF_SCR0, 1'h1, 32'h22, 32'h0, 1'h0}, '{OFF_STAT, 1'h0, 32'h0, 32'h08, 1'h0},
         '{8'h54, 1'h0, 32'h0, 32'h0, 1'h1}, '{8'h02, 1'h0, 32'h0, 32'h0, 1'h1},
         '{OFF_KEYHI, 1'h1, 32'h95A4, 32'h0, 1'h0}, '{OFF_STAT, 1'h0, 32'h0, 32'h00, 1'h0}};
      repeat (12) @(posedge pclk);
      presetn <= 1'h1; rtc_por_n <= 1'h1;
      foreach (rows[i]) begin
         apb(rows[i].a, rows[i].w, rows[i].d);
         chk({31'h0, er}, {31'h0, rows[i].err});
         if (!rows[i].w) chk(rd, rows[i].e);
      end
      repeat (40) @(posedge pclk);
      rc(OFF_SCR0, 32'h0);
      $display("reset and unlock table done");
      apb(OFF_SCR0, 1'h1, 32'h5A);
      rc(OFF_SCR0, 32'h0);
      repeat (40) @(posedge pclk);
      rc(OFF_SCR0, 32'h5A);
      @(posedge pclk) presetn <= 1'h0;
      repeat (3) @(posedge pclk);
      presetn <= 1'h1;
      rc(OFF_SCR0, 32'h5A);
      rc(OFF_STAT, 32'h0);
      $display("write timing and device reset done");
      apb(OFF_CORR, 1'h1, 32'h7F);
      setcal(32'h24, 32'h02, 32'h28);
      repeat (600) @(posedge pclk);
      rc(OFF_DATE, 32'h29);
      rc(OFF_HOUR, 32'h00);
      rc(OFF_CORR, 32'h7F);
      setcal(32'h99, 32'h12, 32'h31);
      apb(OFF_ASEC, 1'h1, 32'h00); apb(OFF_CTRL, 1'h1, 32'h07);
      repeat (600) @(posedge pclk);
      rc(OFF_YEAR, 32'h99);
      rc(OFF_MSEC, 32'h999);
      chk({31'h0, irq}, 32'h0);
      $display("calendar done");
      apb(OFF_YEAR, 1'h1, 32'h00);
      wait_irq();
      chk({31'h0, irq}, 32'h1);
      rc(OFF_STAT, 32'h01);
      apb(OFF_STAT, 1'h1, 32'h01); apb(OFF_CTRL, 1'h1, 32'h08);
      repeat (10) @(posedge pclk);
      wait_irq();
      chk({31'h0, irq}, 32'h1);
      apb(OFF_CTRL, 1'h1, 32'h80); apb(OFF_STAT, 1'h1, 32'h03);
      repeat (40) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      chk({30'h0, wake_oe_n, wake_o}, 32'h0);
      apb(OFF_CTRL, 1'h1, 32'h88);
      wait_irq();
      chk({30'h0, wake_oe_n, wake_o}, 32'h1);
      chk({31'h0, wake_req}, 32'h1);
      apb(OFF_CTRL, 1'h1, 32'h00);
      repeat (40) @(posedge pclk);
      apb(OFF_STAT, 1'h1, 32'h03);
      repeat (10) @(posedge pclk);
      chk({31'h0, wake_req}, 32'h0);
      wake_in <= 1'h1;
      repeat (10) @(posedge pclk);
      chk({30'h0, wake_oe_n, wake_req}, 32'h3);
      rc(OFF_STAT, 32'h04);
      $display("alarm periodic and wake done");
      end_sim();
   end
endmodule
